// ===== cond_fp_move_pkg.sv
package cond_fp_move_pkg;
  // APB geometry
  localparam int AW = 12;
  localparam int DW = 32;
  // Register byte offsets
  localparam logic [AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [AW-1:0] STAT_OFS = 12'h004;
  localparam logic [AW-1:0] MASK_OFS = 12'h008;
  localparam logic [AW-1:0] FSR_OFS = 12'h00c;
  // Control register
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b0;
  // Event bits of status and mask
  localparam int EV_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ILL = 1;
  localparam int EV_OFF = 2;
  localparam int EV_OTH = 3;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;
  // FP status register fields
  localparam int CEXC_LSB = 0;
  localparam int AEXC_LSB = 5;
  localparam int FTT_LSB = 14;
  localparam logic [4:0] CEXC_RESET = 5'h00;
  localparam logic [4:0] AEXC_RESET = 5'h00;
  localparam logic [2:0] FTT_NONE = 3'h0;
  localparam logic [2:0] FTT_UNIMPL = 3'h3;
  // Instruction fields
  localparam int RD_LSB = 25;
  localparam int RSV_BIT = 18;
  localparam int COND_LSB = 14;
  localparam int SEL_LSB = 11;
  localparam int OPF_LSB = 5;
  localparam int RS2_LSB = 0;
  // Condition source select
  localparam logic [2:0] SEL_ICC = 3'h4;
  localparam logic [2:0] SEL_XCC = 3'h6;
  localparam logic [2:0] SEL_BAD0 = 3'h5;
  localparam logic [2:0] SEL_BAD1 = 3'h7;
  // Operation format low field
  localparam logic [5:0] OPF_SGL = 6'h01;
  localparam logic [5:0] OPF_DBL = 6'h02;
  localparam logic [5:0] OPF_QUAD = 6'h03;
  // FP condition field values: equal, less, greater, unordered
  localparam logic [1:0] FCC_E = 2'h0;
  localparam logic [1:0] FCC_L = 2'h1;
  localparam logic [1:0] FCC_G = 2'h2;
  localparam logic [1:0] FCC_U = 2'h3;
endpackage

// ===== cond_fp_move_unit.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Integer codes: 1000 always, 0000 never, 1001 Z clear, 0001 Z set.
// - Signed tests: 1010 not(Z or N^V), 0010 inverse, 1011 N==V, 0011 N!=V.
// - Unsigned tests: 1100 not(C or Z), 0100 C or Z, 1101 C clear, 0101 C set.
// - 1110 N clear, 0110 N set, 1111 V clear, 0111 V set.
// - FP codes: 1000 always, 0000 never, 0111 unordered, 0110 greater.
// - FP 0101 G or U, 0100 L, 0011 L or U, 0010 L or G, 0001 L, G or U.
// - FP 1001 E, 1010 E/U, 1011 E/G, 1100 E/G/U, 1101 E/L, 1110 E/L/U, 1111 ordered.
// - Select 100 picks 32-bit codes, 110 64-bit codes, 000-011 FP fields.
// - Bit 18 set or select 101/111 raises illegal-opcode trap.
// - True condition copies source register to destination, false leaves it.
// - Condition codes are only read, never written.
// - An executed move clears current exceptions and trap type.
// - No rounding, accrued exceptions kept, NaN patterns copied unchanged.
// - Quad moves are never executed in hardware, left to software.
// - Quad move with FPU disabled or absent raises FPU-off trap.
// - Quad move with FPU enabled raises other-FP trap, type unimplemented.
// - Low format 000001 single, 000010 double, 000011 quad.
module cond_fp_move_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cond_fp_move_pkg::AW-1:0] paddr,
  input wire logic [cond_fp_move_pkg::DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [cond_fp_move_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] src_fp_data,
  input wire logic [3:0] icc,
  input wire logic [3:0] xcc,
  input wire logic [1:0] fp_cond_field_zero,
  input wire logic [1:0] fp_cond_field_one,
  input wire logic [1:0] fp_cond_field_two,
  input wire logic [1:0] fp_cond_field_three,
  input wire logic proc_fp_enable_bit,
  input wire logic fpu_present,
  output logic done,
  output logic freg_we,
  output logic freg_dbl,
  output logic [4:0] freg_dst,
  output logic [63:0] freg_wdata,
  output logic illegal_trap,
  output logic fpu_off_trap,
  output logic fp_other_trap,
  output logic [4:0] current_fp_exceptions,
  output logic [4:0] accrued_fp_exceptions,
  output logic [2:0] fp_trap_type
);
  import cond_fp_move_pkg::*;

  // Integer test; flags are {N,Z,V,C}, upper cond bit inverts
  function automatic logic int_test(input logic [3:0] c, input logic [3:0] f);
    logic t;
    t = 1'b0;
    case (c[2:0])
      3'h0: t = 1'b0;
      3'h1: t = f[2];
      3'h2: t = f[2] | (f[3] ^ f[1]);
      3'h3: t = f[3] ^ f[1];
      3'h4: t = f[0] | f[2];
      3'h5: t = f[0];
      3'h6: t = f[3];
      default: t = f[1];
    endcase
    return c[3] ? ~t : t;
  endfunction

  // FP test; upper cond bit again inverts the lower group
  function automatic logic fp_test(input logic [3:0] c, input logic [1:0] f);
    logic e, l, g, u, t;
    e = (f == FCC_E);
    l = (f == FCC_L);
    g = (f == FCC_G);
    u = (f == FCC_U);
    t = 1'b0;
    case (c[2:0])
      3'h0: t = 1'b0;
      3'h1: t = l | g | u;
      3'h2: t = l | g;
      3'h3: t = l | u;
      3'h4: t = l;
      3'h5: t = g | u;
      3'h6: t = g;
      default: t = u;
    endcase
    return c[3] ? ~t : t;
  endfunction

  logic unit_fp_enable_bit_r;
  logic [EV_W-1:0] stat_r, stat_nxt, mask_r;
  logic [4:0] cexc_r, aexc_r;
  logic [2:0] ftt_r;
  logic [DW-1:0] prdata_r;
  logic pready_r, pslverr_r, irq_r;
  logic done_r, we_r, dbl_r, ill_r, off_r, oth_r;
  logic [4:0] dst_r;
  logic [63:0] wdata_r;

  logic [2:0] sel_c;
  logic [3:0] cond_c;
  logic [5:0] opf_c;
  logic [1:0] fcc_c;
  logic is_int_c, quad_c, fmt_ok_c, ill_c, off_c, oth_c, pass_c, go_c;
  logic setup_c, wr_c, rd_c, hit_c;

  // Field split and source selection
  always_comb begin
    sel_c = instr[SEL_LSB +: 3];
    cond_c = instr[COND_LSB +: 4];
    opf_c = instr[OPF_LSB +: 6];
    is_int_c = (sel_c == SEL_ICC) || (sel_c == SEL_XCC);
    case (sel_c[1:0])
      2'h0: fcc_c = fp_cond_field_zero;
      2'h1: fcc_c = fp_cond_field_one;
      2'h2: fcc_c = fp_cond_field_two;
      default: fcc_c = fp_cond_field_three;
    endcase
  end

  // Format decode and trap priority
  always_comb begin
    quad_c = (opf_c == OPF_QUAD);
    fmt_ok_c = (opf_c == OPF_SGL) || (opf_c == OPF_DBL) || quad_c;
    ill_c = instr[RSV_BIT] || (sel_c == SEL_BAD0) || (sel_c == SEL_BAD1)
            || !fmt_ok_c;
    off_c = !ill_c && !(unit_fp_enable_bit_r && proc_fp_enable_bit && fpu_present);
    oth_c = !ill_c && !off_c && quad_c;
    go_c = issue_valid && !ill_c && !off_c && !quad_c;
  end

  // Condition evaluation; codes are read only
  always_comb begin
    if (sel_c == SEL_XCC) begin
      pass_c = int_test(cond_c, xcc);
    end else if (is_int_c) begin
      pass_c = int_test(cond_c, icc);
    end else begin
      pass_c = fp_test(cond_c, fcc_c);
    end
  end

  // Execution results, one cycle after issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      we_r <= 1'b0;
      dbl_r <= 1'b0;
      dst_r <= 5'h00;
      wdata_r <= 64'h0;
    end else begin
      done_r <= issue_valid;
      we_r <= go_c && pass_c;
      if (go_c && pass_c) begin
        dbl_r <= (opf_c == OPF_DBL);
        dst_r <= instr[RD_LSB +: 5];
        wdata_r <= src_fp_data;
      end
    end
  end

  // Trap outputs; at most one per instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ill_r <= 1'b0;
      off_r <= 1'b0;
      oth_r <= 1'b0;
    end else begin
      ill_r <= issue_valid && ill_c;
      off_r <= issue_valid && off_c;
      oth_r <= issue_valid && oth_c;
    end
  end

  // APB decode
  always_comb begin
    setup_c = psel && !penable && !pready_r;
    wr_c = psel && penable && pready_r && pwrite && !pslverr_r;
    rd_c = setup_c && !pwrite;
    hit_c = (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == MASK_OFS)
            || (paddr == FSR_OFS);
  end

  // Bus answer, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup_c;
      pslverr_r <= setup_c && !hit_c;
      if (rd_c) begin
        case (paddr)
          CTRL_OFS: prdata_r <= {31'h0, unit_fp_enable_bit_r};
          STAT_OFS: prdata_r <= {28'h0, stat_r};
          MASK_OFS: prdata_r <= {28'h0, mask_r};
          FSR_OFS: prdata_r <= {15'h0, ftt_r, 4'h0, aexc_r, cexc_r};
          default: prdata_r <= 32'h0;
        endcase
      end else if (setup_c) begin
        prdata_r <= 32'h0;
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_fp_enable_bit_r <= CTRL_EN_RESET;
      mask_r <= EV_RESET;
    end else if (wr_c && pstrb[0]) begin
      if (paddr == CTRL_OFS) begin
        unit_fp_enable_bit_r <= pwdata[CTRL_EN_BIT];
      end
      if (paddr == MASK_OFS) begin
        mask_r <= pwdata[EV_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_c && pstrb[0] && (paddr == STAT_OFS)) begin
      stat_nxt = stat_r & ~pwdata[EV_W-1:0];
    end
    stat_nxt[EV_DONE] = stat_nxt[EV_DONE] | done_r;
    stat_nxt[EV_ILL] = stat_nxt[EV_ILL] | ill_r;
    stat_nxt[EV_OFF] = stat_nxt[EV_OFF] | off_r;
    stat_nxt[EV_OTH] = stat_nxt[EV_OTH] | oth_r;
  end

  // Status and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= EV_RESET;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // FP status fields; the move outranks a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cexc_r <= CEXC_RESET;
      aexc_r <= AEXC_RESET;
      ftt_r <= FTT_NONE;
    end else begin
      if (wr_c && (paddr == FSR_OFS)) begin
        if (pstrb[0]) begin
          cexc_r <= pwdata[CEXC_LSB +: 5];
        end
        if (pstrb[1] || pstrb[0]) begin
          aexc_r <= pwdata[AEXC_LSB +: 5];
        end
        if (pstrb[1]) begin
          ftt_r <= pwdata[FTT_LSB +: 3];
        end
      end
      if (issue_valid && !ill_c && !off_c) begin
        cexc_r <= CEXC_RESET;
        ftt_r <= quad_c ? FTT_UNIMPL : FTT_NONE;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign done = done_r;
  assign freg_we = we_r;
  assign freg_dbl = dbl_r;
  assign freg_dst = dst_r;
  assign freg_wdata = wdata_r;
  assign illegal_trap = ill_r;
  assign fpu_off_trap = off_r;
  assign fp_other_trap = oth_r;
  assign current_fp_exceptions = cexc_r;
  assign accrued_fp_exceptions = aexc_r;
  assign fp_trap_type = ftt_r;

  // Checks on the decode and execution path
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_int_always: assert property (
    go_c && sel_c == SEL_ICC && cond_c == 4'h8 |=> freg_we)
    else $error("always condition did not move");

  a_int_signed: assert property (
    go_c && sel_c == SEL_ICC && cond_c == 4'ha && !icc[2] && icc[3] == icc[1]
    |=> freg_we && freg_wdata == $past(src_fp_data))
    else $error("greater test failed to move");

  a_int_carry: assert property (
    go_c && sel_c == SEL_ICC && cond_c == 4'h5 && !icc[0] |=> done && !freg_we)
    else $error("carry set test moved with carry clear");

  a_int_negative: assert property (
    go_c && sel_c == SEL_ICC && cond_c == 4'he && icc[3] |=> !freg_we)
    else $error("positive test moved on negative");

  a_fp_never: assert property (
    go_c && !is_int_c && cond_c == 4'h0 |=> !freg_we)
    else $error("never condition moved");

  a_fp_unord_less: assert property (
    go_c && sel_c == 3'h3 && cond_c == 4'h3 && fp_cond_field_three == FCC_U
    |=> freg_we)
    else $error("unordered or less failed on unordered");

  a_fp_ordered: assert property (
    go_c && sel_c == 3'h1 && cond_c == 4'hf && fp_cond_field_one == FCC_U
    |=> !freg_we)
    else $error("ordered test moved on unordered");

  a_xcc_select: assert property (
    go_c && sel_c == SEL_XCC && cond_c == 4'h1 && xcc[2] && !icc[2] |=> freg_we)
    else $error("wide codes not selected");

  a_bad_select: assert property (
    issue_valid && (sel_c == SEL_BAD0 || instr[RSV_BIT])
    |=> illegal_trap && !freg_we ##1 !illegal_trap || $past(issue_valid))
    else $error("reserved encoding not trapped");

  a_dest_kept: assert property (
    !issue_valid |=> !freg_we && $stable(freg_wdata) && $stable(freg_dst))
    else $error("destination changed without a move");

  a_fsr_clear: assert property (
    go_c |=> current_fp_exceptions == 5'h00 && fp_trap_type == FTT_NONE)
    else $error("move left exception fields set");

  a_aexc_keep: assert property (
    !(psel && pwrite) |=> $stable(accrued_fp_exceptions))
    else $error("accrued exceptions changed by a move");

  a_quad_unimpl: assert property (
    issue_valid && oth_c
    |=> fp_other_trap && !freg_we && fp_trap_type == FTT_UNIMPL)
    else $error("quad move not reported unimplemented");

  a_quad_off: assert property (
    issue_valid && quad_c && !ill_c && !proc_fp_enable_bit |=> fpu_off_trap)
    else $error("disabled FPU not trapped");

  a_one_trap: assert property (
    $onehot0({illegal_trap, fpu_off_trap, fp_other_trap})
    && !(freg_we && (illegal_trap || fpu_off_trap || fp_other_trap)))
    else $error("more than one trap or trap with write");

  a_irq_level: assert property (
    irq == |(stat_r & $past(mask_r)))
    else $error("interrupt not raised");

  c_move_taken: cover property (go_c && pass_c ##1 freg_we);
  c_quad_trap: cover property (issue_valid && oth_c ##1 fp_other_trap);
  c_irq_clear: cover property (irq ##[1:20] !irq);
endmodule

// ===== cond_fp_move_unit_tb_top.sv
`timescale 1ns/1ps
module cond_fp_move_unit_tb_top;
  import cond_fp_move_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, issue_valid, done;
  logic proc_fp_enable_bit, fpu_present, freg_we, freg_dbl, err_v;
  logic illegal_trap, fpu_off_trap, fp_other_trap;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, rd_v;
  logic [3:0] pstrb, icc, xcc;
  logic [31:0] instr;
  logic [63:0] src_fp_data, freg_wdata, mdl_data;
  logic [1:0] fz, fo, ft, fh;
  logic [4:0] freg_dst, current_fp_exceptions, accrued_fp_exceptions, mdl_idx;
  logic [2:0] fp_trap_type;
  int mismatches, tests_run;
  // Hit masks {U,G,L,E} for each floating-point condition code
  logic [3:0] fmask [16] = '{4'h0, 4'he, 4'h6, 4'ha, 4'h2, 4'hc, 4'h4, 4'h8,
                             4'hf, 4'h1, 4'h9, 4'h5, 4'hd, 4'h3, 4'hb, 4'h7};

  cond_fp_move_unit dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .irq, .issue_valid, .instr, .src_fp_data, .icc, .xcc,
    .fp_cond_field_zero(fz), .fp_cond_field_one(fo), .fp_cond_field_two(ft),
    .fp_cond_field_three(fh), .proc_fp_enable_bit, .fpu_present, .done, .freg_we,
    .freg_dbl, .freg_dst, .freg_wdata, .illegal_trap, .fpu_off_trap, .fp_other_trap,
    .current_fp_exceptions, .accrued_fp_exceptions, .fp_trap_type
  );

  fp_regfile_model mdl_u (
    .pclk, .freg_we, .freg_dbl, .freg_dst, .freg_wdata, .rd_idx(mdl_idx), .rd_data(mdl_data)
  );

  // Free-running 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high or 20 access cycles have passed
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_v = prdata;
    err_v = pslverr;
    if (pready !== 1'b1) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string msg);
    apb(1'b0, a, '0);
    chk(rd_v, exp, msg);
    chk(err_v, 1'b0, msg);
  endtask

  // One-cycle issue pulse, outputs settled after the answering edge
  task automatic issue(input logic [31:0] ins, input logic [63:0] d);
    @(posedge pclk);
    instr <= ins;
    src_fp_data <= d;
    issue_valid <= 1'b1;
    @(posedge pclk);
    issue_valid <= 1'b0;
    #1;
  endtask

  function automatic logic [31:0] mk(input logic [3:0] c, input logic [2:0] s,
      input logic [5:0] o, input logic [4:0] rd);
    return (32'(rd) << RD_LSB) | (32'(c) << COND_LSB) | (32'(s) << SEL_LSB)
           | (32'(o) << OPF_LSB);
  endfunction

  // Expected outcome of a condition; f is {N,Z,V,C}, q the chosen fp field
  function automatic logic hit(input logic [3:0] c, input logic [2:0] s,
      input logic [3:0] f, input logic [1:0] q);
    logic n, z, v, cy;
    {n, z, v, cy} = f;
    if (!s[2]) return fmask[c][q];
    // One entry per integer condition code
    case (c)
      4'h8: return 1'b1;
      4'h0: return 1'b0;
      4'h9: return !z;
      4'h1: return z;
      4'ha: return !(z || (n ^ v));
      4'h2: return z || (n ^ v);
      4'hb: return n == v;
      4'h3: return n != v;
      4'hc: return !(cy || z);
      4'h4: return cy || z;
      4'hd: return !cy;
      4'h5: return cy;
      4'he: return !n;
      4'h6: return n;
      4'hf: return !v;
      default: return v;
    endcase
  endfunction

  task automatic move(input logic [31:0] ins, input logic [63:0] d, input logic e);
    issue(ins, d);
    chk(done, 1'b1, "done");
    chk({illegal_trap, fpu_off_trap, fp_other_trap}, 3'b000, "trap");
    chk(freg_we, e, "write strobe");
    if (e) begin
      chk(freg_wdata, d, "data");
      chk(freg_dst, ins[29:25], "dest");
      chk(freg_dbl, ins[10:5] == OPF_DBL, "width");
    end
  endtask

  task automatic trap(input logic [31:0] ins, input logic [2:0] e);
    issue(ins, 64'h0);
    chk({illegal_trap, fpu_off_trap, fp_other_trap}, e, "trap kind");
    chk(freg_we, 1'b0, "no write");
  endtask

  task automatic t_regs;
    rchk(CTRL_OFS, 32'h0, "ctrl reset");
    rchk(STAT_OFS, 32'h0, "stat reset");
    rchk(MASK_OFS, 32'h0, "mask reset");
    rchk(FSR_OFS, 32'h0, "fsr reset");
    apb(1'b0, 12'h010, 32'h0);
    chk({err_v, rd_v}, {1'b1, 32'h0}, "unmapped");
    trap(mk(4'h8, SEL_ICC, OPF_SGL, 5'd1), 3'b010);
    apb(1'b1, CTRL_OFS, 32'h1);
    rchk(CTRL_OFS, 32'h1, "ctrl rw");
  endtask

  task automatic t_int;
    logic [3:0] f;
    logic [2:0] s;
    for (int c = 0; c < 16; c++) begin
      for (int k = 0; k < 4; k++) begin
        f = 4'(c * 5 + k * 7);
        s = k[0] ? SEL_XCC : SEL_ICC;
        @(posedge pclk);
        icc <= f;
        xcc <= ~f;
        move(mk(4'(c), s, OPF_SGL, 5'(c)), {32'(k), 32'(c)}, hit(4'(c), s, k[0] ? ~f : f, 2'h0));
      end
    end
  endtask

  task automatic t_fp;
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge pclk);
        fz <= 2'(c);
        fo <= 2'(c + 1);
        ft <= 2'(c + 2);
        fh <= 2'(c + 3);
        move(mk(4'(c), 3'(s), c[0] ? OPF_DBL : OPF_SGL, 5'(c + s)), {32'(s), 32'(c)},
             hit(4'(c), 3'(s), 4'h0, 2'(c + s)));
      end
    end
  endtask

  task automatic t_traps;
    trap(mk(4'h8, SEL_ICC, OPF_SGL, 5'd0) | (32'h1 << RSV_BIT), 3'b100);
    trap(mk(4'h8, SEL_BAD0, OPF_DBL, 5'd0), 3'b100);
    trap(mk(4'h8, SEL_BAD1, OPF_QUAD, 5'd0), 3'b100);
    trap(mk(4'h0, SEL_XCC, OPF_QUAD, 5'd0), 3'b001);
    chk(fp_trap_type, FTT_UNIMPL, "ftt unimpl");
    @(posedge pclk);
    proc_fp_enable_bit <= 1'b0;
    trap(mk(4'h8, 3'h0, OPF_QUAD, 5'd0), 3'b010);
    trap(mk(4'h8, 3'h0, OPF_QUAD, 5'd0) | (32'h1 << RSV_BIT), 3'b100);
    @(posedge pclk);
    proc_fp_enable_bit <= 1'b1;
    fpu_present <= 1'b0;
    trap(mk(4'h8, SEL_ICC, OPF_QUAD, 5'd0), 3'b010);
    @(posedge pclk);
    fpu_present <= 1'b1;
  endtask

  task automatic t_fsr;
    logic [31:0] w;
    w = (32'h15 << AEXC_LSB) | 32'h1f | (32'(FTT_UNIMPL) << FTT_LSB);
    apb(1'b1, FSR_OFS, w);
    rchk(FSR_OFS, w, "fsr rw");
    move(mk(4'h8, SEL_ICC, OPF_DBL, 5'd7), 64'h7ff8_0000_dead_beef, 1'b1);
    chk({current_fp_exceptions, fp_trap_type}, {5'h00, FTT_NONE}, "cleared");
    chk(accrued_fp_exceptions, 5'h15, "aexc kept");
    @(posedge pclk);
    mdl_idx <= 5'd7;
    move(mk(4'h0, SEL_ICC, OPF_DBL, 5'd7), 64'h1, 1'b0);
    @(posedge pclk);
    #1;
    chk(mdl_data, 64'h7ff8_0000_dead_beef, "dest kept");
  endtask

  task automatic t_irq;
    apb(1'b1, STAT_OFS, 32'hf);
    trap(mk(4'h8, SEL_ICC, OPF_QUAD, 5'd0), 3'b001);
    rchk(STAT_OFS, (32'h1 << EV_OTH) | (32'h1 << EV_DONE), "event bit");
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, MASK_OFS, 32'h1 << EV_OTH);
    repeat (2) @(posedge pclk);
    #1;
    chk(irq, 1'b1, "irq on");
    apb(1'b1, STAT_OFS, 32'hf);
    repeat (2) @(posedge pclk);
    #1;
    chk(irq, 1'b0, "irq cleared");
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, issue_valid, paddr, pwdata} = '0;
    {instr, src_fp_data, icc, xcc, fz, fo, ft, fh, mdl_idx} = '0;
    {proc_fp_enable_bit, fpu_present, pstrb} = 6'h3f;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_int();
    t_fp();
    t_traps();
    t_fsr();
    t_irq();
    report_and_stop();
  end

  // Watchdog at 10,000 cycles, well beyond the few hundred needed
  initial begin
    #250_000;
    mismatches++;
    report_and_stop();
  end
endmodule

// ===== fp_regfile_model.sv
`timescale 1ns/1ps
// Destination register file on the far side of the move unit
module fp_regfile_model (
  input wire logic pclk,
  input wire logic freg_we,
  input wire logic freg_dbl,
  input wire logic [4:0] freg_dst,
  input wire logic [63:0] freg_wdata,
  input wire logic [4:0] rd_idx,
  output logic [63:0] rd_data
);
  logic [63:0] regs_r [32];
  // Strobed copy, bits kept as delivered; a single leaves the upper half
  always_ff @(posedge pclk) begin
    if (freg_we) begin
      regs_r[freg_dst][31:0] <= freg_wdata[31:0];
      if (freg_dbl) begin
        regs_r[freg_dst][63:32] <= freg_wdata[63:32];
      end
    end
  end
  assign rd_data = regs_r[rd_idx];
endmodule
